// ### rtl/bec_map.vh
`ifndef BEC_CAPTURE_MAP_VH
`define BEC_CAPTURE_MAP_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define BEC_OFF_SYND0       12'h600
`define BEC_OFF_SYND1       12'h640
`define BEC_OFF_SYND2       12'h680
`define BEC_OFF_SYND3       12'h6c0
`define BEC_OFF_CMD_LOW     12'h700
`define BEC_OFF_CMD_HIGH    12'h740
`define BEC_OFF_STATUS      12'h780
`define BEC_OFF_MASK        12'h7c0

// ----------------------------------------------------------------------------
// Status and mask bit positions
// ----------------------------------------------------------------------------
`define BEC_ST_CE           0
`define BEC_ST_UCE          1
`define BEC_ST_CE2          2
`define BEC_ST_SECOND_UNCORRECTABLE_FLAG         3
`define BEC_ST_CMDLOCK      4
`define BEC_ST_W            5

// ----------------------------------------------------------------------------
// Bus and field layout
// ----------------------------------------------------------------------------
`define BEC_LW_W            32
`define BEC_SYN_W           7
`define BEC_NUM_LW          4
`define BEC_BUS_PAR_BIT     38
`define BEC_BUS_CMD_HI      37
`define BEC_BUS_CMD_LO      35
`define BEC_BUS_ADDR_HI     34
`define BEC_BUS_ADDR_LO     32

// ----------------------------------------------------------------------------
// Reset values and other constants
// ----------------------------------------------------------------------------
`define BEC_ZERO32          32'h0000_0000
`define BEC_ZERO7           7'h00
`define BEC_ZERO5           5'h00
`define BEC_ZERO4           4'h0
`define BEC_ZERO3           3'h0
`define BEC_ZERO2           2'h0
`define BEC_ONE7            7'h01
`define BEC_ONE2            2'h1

// ----------------------------------------------------------------------------
// Check-code columns, data bit 31 on the left down to bit 0 on the right
// ----------------------------------------------------------------------------
`define BEC_H_COLS {7'h75, 7'h70, 7'h6d, 7'h6b, 7'h68, 7'h67, 7'h64, 7'h62, \
                    7'h1c, 7'h1a, 7'h19, 7'h16, 7'h0d, 7'h15, 7'h13, 7'h0b, \
                    7'h0e, 7'h34, 7'h31, 7'h2c, 7'h2a, 7'h29, 7'h26, 7'h25, \
                    7'h23, 7'h5d, 7'h58, 7'h57, 7'h54, 7'h52, 7'h4a, 7'h4f}

`endif

// ### rtl/bec_capture.v
// Functional notes
// - Syndrome is generated checks XOR received checks
// - Four 7-bit syndromes, one per longword slice
// - Syndrome registers load and lock on first error
// - Later ECC errors set second-error flags only
// - Zero syndrome means longword has no error
// - Each single-bit error has a distinct syndrome
// - Other non-zero syndromes are uncorrectable double errors
// - Locking error saves command-cycle command and address
// - Command capture locks on listed bus/interface errors
// - Low command register holds data lines 31:0
// - Bits 19:18 record failing data beat 0-3
// - Bits 17:15 hold dirty, shared, confirmation seen
// - Bits 14:11 commander ident, 10:7 its copy
// - Bits 5:3 command lines 37:35, 2:0 address 34:32
// - Reserved upper bits always read as zero
`timescale 1ns/1ps
`include "bec_map.vh"

module bec_capture (
  input  wire         clk,
  input  wire         rstn,
  // Register port
  input  wire [11:0]  regAddr,
  input  wire [31:0]  regWrData,
  input  wire         regWrEn,
  input  wire         regRdEn,
  output reg  [31:0]  regRdData,
  // System bus, sampled on the module clock
  input  wire         busCmdValid,
  input  wire         busDataValid,
  input  wire [127:0] busData,
  input  wire [27:0]  busEcc,
  input  wire [3:0]   busReq,
  input  wire         busDirty,
  input  wire         busShared,
  input  wire         busCnf,
  // Other locking error events, one-cycle pulses
  input  wire         cmdParityErr,
  input  wire         csrParityErr,
  input  wire         nxmErr,
  input  wire         arbDropErr,
  input  wire [3:0]   pageMapParityErr,
  input  wire         tagParityErr,
  input  wire         tagStatusParityErr,
  input  wire         cacheMapParityErr,
  // Flags toward the error summary logic
  output reg          correctableErrFlag,
  output reg          uncorrectable_err_flag,
  output reg          second_correctable_flag,
  output reg          second_uncorrectable_flag,
  output reg          irq
);

  // --------------------------------------------------------------------------
  // Check-code helpers
  // --------------------------------------------------------------------------

  // Syndrome of one longword against its received check slice
  function [6:0] bec_syn;
    input [31:0] data;
    input [6:0]  chk;
    integer      i;
    reg   [6:0]  gen;
    reg   [223:0] cols;
    begin
      cols = `BEC_H_COLS;
      gen  = `BEC_ZERO7;
      for (i = 0; i < `BEC_LW_W; i = i + 1)
      begin
        if (data[i])
          gen = gen ^ cols[i*`BEC_SYN_W +: `BEC_SYN_W];
      end
      bec_syn = gen ^ chk;
    end
  endfunction

  // True when a non-zero syndrome names one flipped bit
  function bec_single;
    input [6:0] syn;
    integer     i;
    reg   [223:0] cols;
    begin
      cols       = `BEC_H_COLS;
      bec_single = ((syn & (syn - `BEC_ONE7)) == `BEC_ZERO7); // Check bit alone
      for (i = 0; i < `BEC_LW_W; i = i + 1)
      begin
        if (cols[i*`BEC_SYN_W +: `BEC_SYN_W] == syn)
          bec_single = 1'b1;
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // Per-beat syndrome and classification
  // --------------------------------------------------------------------------
  reg  [27:0] synNow;
  reg         anyErr;
  reg         anyDouble;
  integer     k;

  // All four longwords are checked in parallel on every data beat
  always @*
  begin
    synNow    = {`BEC_ZERO7, `BEC_ZERO7, `BEC_ZERO7, `BEC_ZERO7};
    anyErr    = 1'b0;
    anyDouble = 1'b0;
    for (k = 0; k < `BEC_NUM_LW; k = k + 1)
    begin
      synNow[k*`BEC_SYN_W +: `BEC_SYN_W] =
        bec_syn(busData[k*`BEC_LW_W +: `BEC_LW_W], busEcc[k*`BEC_SYN_W +: `BEC_SYN_W]);
      if (synNow[k*`BEC_SYN_W +: `BEC_SYN_W] != `BEC_ZERO7)
      begin
        anyErr = 1'b1;
        if (!bec_single(synNow[k*`BEC_SYN_W +: `BEC_SYN_W]))
          anyDouble = 1'b1;
      end
    end
  end

  wire eccEvent  = busDataValid & anyErr;
  wire ceEvent   = eccEvent & ~anyDouble;
  wire uceEvent  = eccEvent & anyDouble;
  wire otherErr  = cmdParityErr | csrParityErr | nxmErr | arbDropErr | (|pageMapParityErr) |
                   tagParityErr | tagStatusParityErr | cacheMapParityErr;
  wire lockEvent = eccEvent | otherErr;

  // --------------------------------------------------------------------------
  // Command-cycle holding
  // --------------------------------------------------------------------------
  reg  [31:0] holdLow_reg;
  reg  [10:0] holdCmd_reg;   // Parity, command, address 34:32
  reg  [3:0]  holdCid_reg;
  reg  [1:0]  beatCnt_reg;
  reg         holdDirty_reg;
  reg         holdShared_reg;
  reg         holdCnf_reg;

  // Fields are held from each command cycle until the next, so a late error
  // still finds the command of its own transaction
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      holdLow_reg    <= `BEC_ZERO32;
      holdCmd_reg    <= {`BEC_ZERO7, `BEC_ZERO4};
      holdCid_reg    <= `BEC_ZERO4;
      beatCnt_reg    <= `BEC_ZERO2;
      holdDirty_reg  <= 1'b0;
      holdShared_reg <= 1'b0;
      holdCnf_reg    <= 1'b0;
    end
    else if (busCmdValid)
    begin
      holdLow_reg    <= busData[`BEC_LW_W-1:0];
      holdCmd_reg    <= {`BEC_ZERO4, busData[`BEC_BUS_PAR_BIT:`BEC_BUS_ADDR_LO]};
      holdCid_reg    <= busReq;
      beatCnt_reg    <= `BEC_ZERO2;
      holdDirty_reg  <= busDirty;
      holdShared_reg <= busShared;
      holdCnf_reg    <= busCnf;
    end
    else
    begin
      if (busDataValid)
        beatCnt_reg <= beatCnt_reg + `BEC_ONE2; // Beat after 3 wraps, transaction is over
      // Sticky for the transaction: these can arrive after the command cycle
      holdDirty_reg  <= holdDirty_reg | busDirty;
      holdShared_reg <= holdShared_reg | busShared;
      holdCnf_reg    <= holdCnf_reg | busCnf;
    end
  end

  // --------------------------------------------------------------------------
  // Capture registers and flags
  // --------------------------------------------------------------------------
  reg  [27:0]            synCap_reg;
  reg  [31:0]            cmdLow_reg;
  reg  [19:0]            cmdHigh_reg;
  reg  [`BEC_ST_W-1:0]   status_reg;
  reg  [`BEC_ST_W-1:0]   status_next;
  reg  [`BEC_ST_W-1:0]   mask_reg;

  wire synLocked = status_reg[`BEC_ST_CE] | status_reg[`BEC_ST_UCE];
  wire wrStatus  = regWrEn && (regAddr == `BEC_OFF_STATUS);
  wire [`BEC_ST_W-1:0] clrBits = wrStatus ? regWrData[`BEC_ST_W-1:0] : `BEC_ZERO5;

  // Hardware set beats a simultaneous software clear
  always @*
  begin
    status_next = status_reg & ~clrBits;
    if (ceEvent & ~synLocked)
      status_next[`BEC_ST_CE] = 1'b1;
    if (uceEvent & ~synLocked)
      status_next[`BEC_ST_UCE] = 1'b1;
    if (ceEvent & synLocked)
      status_next[`BEC_ST_CE2] = 1'b1;
    if (uceEvent & synLocked)
      status_next[`BEC_ST_SECOND_UNCORRECTABLE_FLAG] = 1'b1;
    if (lockEvent)
      status_next[`BEC_ST_CMDLOCK] = 1'b1;
  end

  // Capture registers load only while unlocked; software cannot write them
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      synCap_reg  <= {`BEC_ZERO7, `BEC_ZERO7, `BEC_ZERO7, `BEC_ZERO7};
      cmdLow_reg  <= `BEC_ZERO32;
      cmdHigh_reg <= {`BEC_ZERO4, `BEC_ZERO4, `BEC_ZERO4, `BEC_ZERO4, `BEC_ZERO4};
      status_reg  <= `BEC_ZERO5;
      mask_reg    <= `BEC_ZERO5;
    end
    else
    begin
      status_reg <= status_next;
      if (eccEvent && !synLocked)
        synCap_reg <= synNow;
      if (lockEvent && !status_reg[`BEC_ST_CMDLOCK])
      begin
        cmdLow_reg  <= holdLow_reg;
        cmdHigh_reg <= {beatCnt_reg,
                        holdDirty_reg, holdShared_reg, holdCnf_reg,
                        holdCid_reg, holdCid_reg,
                        holdCmd_reg[6:0]};
      end
      if (regWrEn && (regAddr == `BEC_OFF_MASK))
        mask_reg <= regWrData[`BEC_ST_W-1:0];
    end
  end

  // --------------------------------------------------------------------------
  // Read port and outputs
  // --------------------------------------------------------------------------
  reg [31:0] rdMux;

  // Unmapped addresses and reserved bits read zero; writes to capture
  // registers fall through with no effect
  always @*
  begin
    if (regAddr == `BEC_OFF_SYND0)
      rdMux = {25'h0000000, synCap_reg[6:0]};
    else if (regAddr == `BEC_OFF_SYND1)
      rdMux = {25'h0000000, synCap_reg[13:7]};
    else if (regAddr == `BEC_OFF_SYND2)
      rdMux = {25'h0000000, synCap_reg[20:14]};
    else if (regAddr == `BEC_OFF_SYND3)
      rdMux = {25'h0000000, synCap_reg[27:21]};
    else if (regAddr == `BEC_OFF_CMD_LOW)
      rdMux = cmdLow_reg;
    else if (regAddr == `BEC_OFF_CMD_HIGH)
      rdMux = {12'h000, cmdHigh_reg};
    else if (regAddr == `BEC_OFF_STATUS)
      rdMux = {27'h0000000, status_reg};
    else if (regAddr == `BEC_OFF_MASK)
      rdMux = {27'h0000000, mask_reg};
    else
      rdMux = `BEC_ZERO32;
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      regRdData                 <= `BEC_ZERO32;
      irq                       <= 1'b0;
      correctableErrFlag        <= 1'b0;
      uncorrectable_err_flag    <= 1'b0;
      second_correctable_flag   <= 1'b0;
      second_uncorrectable_flag <= 1'b0;
    end
    else
    begin
      regRdData                 <= regRdEn ? rdMux : `BEC_ZERO32;
      irq                       <= |(status_next & mask_reg);
      correctableErrFlag        <= status_next[`BEC_ST_CE];
      uncorrectable_err_flag    <= status_next[`BEC_ST_UCE];
      second_correctable_flag   <= status_next[`BEC_ST_CE2];
      second_uncorrectable_flag <= status_next[`BEC_ST_SECOND_UNCORRECTABLE_FLAG];
    end
  end

endmodule // bec_capture

// ### verif/bec_capture_sva.sv
`timescale 1ns/1ps
`include "bec_map.vh"
module bec_capture_sva (
  input logic         clk,
  input logic         rstn,
  input logic [11:0]  regAddr,
  input logic [31:0]  regWrData,
  input logic         regWrEn,
  input logic         regRdEn,
  input logic [31:0]  regRdData,
  input logic         busDataValid,
  input logic [127:0] busData,
  input logic [27:0]  busEcc,
  input logic         correctableErrFlag,
  input logic         uncorrectable_err_flag,
  input logic         second_correctable_flag,
  input logic         second_uncorrectable_flag
);
  localparam [223:0] HC = `BEC_H_COLS;
  logic [6:0] s;
  logic [3:0] nz;
  logic [3:0] one;
  logic       anyCe;
  logic       anyUce;
  // Own syndrome per longword, so the flags are judged independently
  always_comb
  begin
    for (int k = 0; k < 4; k++)
    begin
      s = busEcc[7*k+:7];
      for (int i = 0; i < 32; i++)
        s = busData[32*k+i] ? s ^ HC[7*i+:7] : s;
      nz[k] = |s;
      one[k] = $onehot(s);
      for (int i = 0; i < 32; i++)
        one[k] = one[k] | (s == HC[7*i+:7]);
    end
    anyCe = |(nz & one);
    anyUce = |(nz & ~one);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ---------
  // Properties
  // ---------
  ecc_seen_a: assert property (busDataValid && |nz |-> ##2 (correctableErrFlag || uncorrectable_err_flag ||
    second_correctable_flag || second_uncorrectable_flag)) else $error("syndrome error not flagged");
  ce_class_a: assert property (busDataValid && anyCe && !anyUce |-> ##2 (correctableErrFlag ||
    second_correctable_flag)) else $error("single error not flagged correctable");
  uce_class_a: assert property (busDataValid && anyUce |-> ##2 (uncorrectable_err_flag ||
    second_uncorrectable_flag)) else $error("double error not flagged");
  ce_cause_a: assert property ($rose(correctableErrFlag) |-> $past(busDataValid) && $past(anyCe))
    else $error("correctable flag without cause");
  second_ce_a: assert property ($rose(second_correctable_flag) |-> $past(correctableErrFlag) ||
    $past(uncorrectable_err_flag)) else $error("second flag without first");
  second_uce_a: assert property ($rose(second_uncorrectable_flag) |-> $past(correctableErrFlag) ||
    $past(uncorrectable_err_flag)) else $error("second flag without first");
  flag_clear_a: assert property ($fell(correctableErrFlag) |-> $past(regWrEn) && $past(regWrData[0]) &&
    $past(regAddr) == `BEC_OFF_STATUS) else $error("flag dropped without clear");
  rsvd_zero_a: assert property ($past(regRdEn) && $past(regAddr[11:8]) == 4'h6 |-> regRdData[31:7] == 25'h0)
    else $error("syndrome reserved bits set");
  cover property ($rose(second_correctable_flag));
  cover property ($rose(uncorrectable_err_flag));
  cover property ($rose(second_uncorrectable_flag));
endmodule // bec_capture_sva

bind bec_capture bec_capture_sva i_sva (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .busDataValid(busDataValid),
  .busData(busData), .busEcc(busEcc), .correctableErrFlag(correctableErrFlag),
  .uncorrectable_err_flag(uncorrectable_err_flag), .second_correctable_flag(second_correctable_flag),
  .second_uncorrectable_flag(second_uncorrectable_flag));

// ### verif/bec_bus_model.sv
`timescale 1ns/1ps
`include "bec_map.vh"
module bec_bus_model (
  input  logic         clk,
  output logic         busCmdValid = 1'h0,
  output logic         busDataValid = 1'h0,
  output logic [127:0] busData = 128'h0,
  output logic [27:0]  busEcc = 28'h0,
  output logic [3:0]   busReq = 4'h0,
  output logic         busDirty = 1'h0,
  output logic         busShared = 1'h0,
  output logic         busCnf = 1'h0
);
  localparam [223:0] HC = `BEC_H_COLS;
  // Check bits a clean sender puts beside the data
  function automatic [27:0] gen(input [127:0] d);
    gen = 28'h0;
    for (int k = 0; k < 4; k++)
      for (int i = 0; i < 32; i++)
        gen[7*k+:7] = d[32*k+i] ? gen[7*k+:7] ^ HC[7*i+:7] : gen[7*k+:7];
  endfunction
  // Command cycle; lines scrambled after it so stale values never look valid
  task cmd(input [38:0] c, input [3:0] r, input [2:0] dsc);
    @(posedge clk);
    busCmdValid <= 1'h1;
    busData[38:0] <= c;
    busReq <= r;
    {busDirty, busShared, busCnf} <= dsc;
    @(posedge clk);
    busCmdValid <= 1'h0;
    busData <= ~busData;
    busReq <= ~r;
    {busDirty, busShared, busCnf} <= 3'h0;
  endtask
  // One data beat, with chosen data and check bits flipped after encoding
  task beat(input [127:0] d, input [127:0] fd, input [27:0] fe);
    @(posedge clk);
    busDataValid <= 1'h1;
    busData <= d ^ fd;
    busEcc <= gen(d) ^ fe;
    @(posedge clk);
    busDataValid <= 1'h0;
    busData <= ~busData;
    busEcc <= ~busEcc;
  endtask
endmodule // bec_bus_model

// ### verif/testbench.sv
`timescale 1ns/1ps
`include "bec_map.vh"
module testbench;
  localparam [223:0] HC = `BEC_H_COLS;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic [11:0] regAddr = 12'h0;
  logic [31:0] regWrData = 32'h0;
  logic regWrEn = 1'h0;
  logic regRdEn = 1'h0;
  logic [10:0] ev = 11'h0;
  logic [127:0] rnd;
  logic [127:0] fd;
  logic [27:0] fe;
  logic [38:0] ca;
  logic [31:0] q;
  logic [3:0] req;
  logic [2:0] dsc;
  logic [6:0] sy;
  wire [31:0] regRdData;
  wire [127:0] busData;
  wire [27:0] busEcc;
  wire [3:0] busReq;
  wire cv, dv, dty, shr, confirmation_seen, f0, f1, f2, f3, irq;
  integer errors = 0;
  integer tests_run = 0;
  integer i, k;
  always #5 clk = ~clk;
  bec_bus_model i_bus (.clk(clk), .busCmdValid(cv), .busDataValid(dv), .busData(busData), .busEcc(busEcc),
    .busReq(busReq), .busDirty(dty), .busShared(shr), .busCnf(confirmation_seen));
  bec_capture i_dut (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .busCmdValid(cv), .busDataValid(dv), .busData(busData),
    .busEcc(busEcc), .busReq(busReq), .busDirty(dty), .busShared(shr), .busCnf(confirmation_seen), .cmdParityErr(ev[0]),
    .csrParityErr(ev[1]), .nxmErr(ev[2]), .arbDropErr(ev[3]), .pageMapParityErr(ev[7:4]),
    .tagParityErr(ev[8]), .tagStatusParityErr(ev[9]), .cacheMapParityErr(ev[10]), .correctableErrFlag(f0),
    .uncorrectable_err_flag(f1), .second_correctable_flag(f2), .second_uncorrectable_flag(f3), .irq(irq));
  // ---------
  // Tasks
  // ---------
  task chk(input [31:0] e, input [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    @(posedge clk);
    regWrEn <= 1'h1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrEn <= 1'h0;
  endtask
  // Read data stands only in the cycle after the strobe
  task rc(input [11:0] a, input [31:0] e);
    @(posedge clk);
    regRdEn <= 1'h1;
    regAddr <= a;
    @(posedge clk);
    regRdEn <= 1'h0;
    #1 chk(e, regRdData);
  endtask
  function [11:0] sa(input integer n);
    sa = 12'h600 + 12'(64 * n);
  endfunction
  function [31:0] hiWord(input [1:0] bt, input [2:0] s, input [3:0] id, input [38:0] c);
    hiWord = {12'h000, bt, s, id, id, c[38:32]};
  endfunction
  // Random command, n clean beats, then one beat with flips
  task xact(input integer n, input [127:0] d, input [27:0] e);
    rnd = {$urandom, $urandom};
    ca = rnd[38:0];
    req = rnd[42:39];
    dsc = rnd[45:43];
    i_bus.cmd(ca, req, dsc);
    repeat (n) i_bus.beat({4{$urandom}}, 128'h0, 28'h0);
    i_bus.beat({4{$urandom}}, d, e);
  endtask
  task conclude;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (30000) @(posedge clk);
    errors++;
    conclude;
  end
  initial
  begin
    q = $urandom(60);
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    for (i = 0; i < 9; i++) rc(sa(i), 32'h0);
    repeat (4) xact(3, 128'h0, 28'h0);
    chk({28'h0, f3, f2, f1, f0}, 32'h0);
    // Every single data or check bit, random longword, failing beat cycling 0-3
    for (i = 0; i < 39; i++)
    begin
      k = $urandom % 4;
      fd = (i < 32) ? 128'h1 << (32 * k + i) : 128'h0;
      fe = (i < 32) ? 28'h0 : 28'h1 << (7 * k + i - 32);
      sy = (i < 32) ? HC[7*i+:7] : 7'h1 << (i - 32);
      xact(i % 4, fd, fe);
      q = hiWord(2'(i % 4), dsc, req, ca);
      rc(12'h780, 32'h11);
      chk({28'h0, f3, f2, f1, f0}, 32'h1);
      rc(sa(k), {25'h0, sy});
      rc(sa((k + 1) % 4), 32'h0);
      rc(12'h700, ca[31:0]);
      rc(12'h740, q);
      xact(0, 128'h1 << (32 * ((k + 1) % 4)), 28'h0);
      rc(12'h780, 32'h15);
      rc(sa(k), {25'h0, sy});
      rc(12'h740, q);
      wr(sa(k), 32'hffffffff);
      rc(sa(k), {25'h0, sy});
      wr(12'h780, 32'h1f);
    end
    xact(1, 128'h3, 28'h0);
    rc(12'h780, 32'h12);
    rc(sa(0), 32'h05);
    xact(2, 128'h3 << 64, 28'h0);
    rc(12'h780, 32'h1a);
    wr(12'h780, 32'h1f);
    // Each non-ECC event alone locks the command capture
    for (i = 0; i < 11; i++)
    begin
      wr(12'h780, 32'h10);
      rnd = {$urandom, $urandom};
      i_bus.cmd(rnd[38:0], rnd[42:39], rnd[45:43]);
      ev <= 11'h1 << i;
      @(posedge clk);
      ev <= 11'h0;
      rc(12'h780, 32'h10);
      rc(12'h700, rnd[31:0]);
    end
    i_bus.cmd(~rnd[38:0], 4'h3, 3'h7);
    ev <= 11'h1;
    @(posedge clk);
    ev <= 11'h0;
    rc(12'h700, rnd[31:0]);
    // Interrupt follows masked status
    chk({31'h0, irq}, 32'h0);
    wr(12'h7c0, 32'h10);
    rc(12'h7c0, 32'h10);
    chk({31'h0, irq}, 32'h1);
    wr(12'h7c0, 32'h01);
    rc(12'h780, 32'h10);
    chk({31'h0, irq}, 32'h0);
    wr(12'h780, 32'h10);
    xact(3, 128'h1 << 96, 28'h0);
    rc(12'h780, 32'h11);
    chk({31'h0, irq}, 32'h1);
    wr(12'h780, 32'h1f);
    rc(12'h780, 32'h0);
    chk({31'h0, irq}, 32'h0);
    conclude;
  end
endmodule // testbench
